// *** uxp_tx_port.sv ***
`timescale 1ns/100ps
// How it works
// - Port pin outputs change only on link clock rising edges while strap high; strap low clears them at once
// - Cell available high when full cell ready and port idle at the link edge
// - Enable seen, next cycle first byte appears
// - Start flag marks first byte cycle
// - Five-bit address sampled to detect selection
// - Strap low ties off all port pins
// - Upper address bits serial unless strap high
// - Each byte driven at link rising edge
module uxp_tx_port #(
  parameter int          CELL_BYTES = uxp_pkg::CELL_BYTES,
  parameter logic [4:0]  OWN_ADDR   = 5'h01
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 cell_port_select_strap,
  input  wire logic                 tx_link_clock,
  input  wire logic                 tx_enable_from_master_n,
  input  wire logic                 tx_slave_select_address_bit0,
  input  wire logic [3:0]           serial_addr_pins_in,
  input  wire logic                 cell_ready,
  input  wire logic [7:0]           cell_byte_in,
  output logic                      cell_byte_take,
  output logic                      serial_addr_pins_route,
  output logic                      tx_cell_available,
  output logic                      tx_cell_available_oe,
  output logic                      tx_start_of_cell,
  output logic                      tx_start_of_cell_oe,
  output logic [7:0]                tx_cell_byte_bus,
  output logic                      tx_cell_byte_bus_oe
);
  localparam int CW = $clog2(CELL_BYTES + 1);

  // Synchronisers for pin inputs
  logic [1:0] clk_s_reg, enb_s_reg, strap_s_reg;
  logic [1:0] clk_s_next, enb_s_next, strap_s_next;
  logic [4:0] adr_s1_reg, adr_s2_reg, adr_s1_next, adr_s2_next;
  logic       clk_d_reg, clk_d_next;
  logic       strap_reg, strap_next;

  always_comb begin
    clk_s_next   = {clk_s_reg[0], tx_link_clock};
    enb_s_next   = {enb_s_reg[0], tx_enable_from_master_n};
    strap_s_next = {strap_s_reg[0], cell_port_select_strap};
    adr_s1_next  = {serial_addr_pins_in, tx_slave_select_address_bit0};
    adr_s2_next  = adr_s1_reg;
    clk_d_next   = clk_s_reg[1];
    strap_next   = strap_s_reg[1];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_s_reg   <= 2'h0;
      enb_s_reg   <= 2'h3;
      strap_s_reg <= 2'h0;
      adr_s1_reg  <= uxp_pkg::NULL_ADDR;
      adr_s2_reg  <= uxp_pkg::NULL_ADDR;
      clk_d_reg   <= 1'b0;
      strap_reg   <= 1'b0;
    end else begin
      clk_s_reg   <= clk_s_next;
      enb_s_reg   <= enb_s_next;
      strap_s_reg <= strap_s_next;
      adr_s1_reg  <= adr_s1_next;
      adr_s2_reg  <= adr_s2_next;
      clk_d_reg   <= clk_d_next;
      strap_reg   <= strap_next;
    end
  end

  // Link rising edge and selection
  logic rise;
  logic sel;
  assign rise = clk_s_reg[1] & ~clk_d_reg;
  assign sel  = strap_reg && (adr_s2_reg == OWN_ADDR);

  // Transmit state and pin registers
  uxp_pkg::uxp_state_t st_reg, st_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic       clav_reg, clav_next, clav_oe_reg, clav_oe_next;
  logic       soc_reg, soc_next, dat_oe_reg, dat_oe_next;
  logic [7:0] dat_reg, dat_next;
  logic       take_reg, take_next, route_reg, route_next;

  always_comb begin
    st_next      = st_reg;
    cnt_next     = cnt_reg;
    clav_next    = clav_reg;
    clav_oe_next = clav_oe_reg;
    soc_next     = soc_reg;
    dat_next     = dat_reg;
    dat_oe_next  = dat_oe_reg;
    take_next    = 1'b0;
    route_next   = ~strap_reg;
    if (!strap_reg) begin
      st_next      = uxp_pkg::UXP_IDLE;
      clav_next    = 1'b0;
      clav_oe_next = 1'b0;
      soc_next     = 1'b0;
      dat_next     = uxp_pkg::IDLE_BYTE;
      dat_oe_next  = 1'b0;
      cnt_next     = '0;
    end else if (rise) begin
      clav_next    = cell_ready && st_reg == uxp_pkg::UXP_IDLE;
      clav_oe_next = sel;
      soc_next     = 1'b0;
      case (st_reg)
        uxp_pkg::UXP_IDLE: begin
          dat_oe_next = 1'b0;
          if (sel && !enb_s_reg[1] && cell_ready) begin
            st_next     = uxp_pkg::UXP_SEND;
            soc_next    = 1'b1;
            dat_next    = cell_byte_in;
            dat_oe_next = 1'b1;
            take_next   = 1'b1;
            cnt_next    = CW'(CELL_BYTES - 1);
          end
        end
        uxp_pkg::UXP_SEND: begin
          if (cnt_reg == '0) begin
            st_next     = uxp_pkg::UXP_IDLE;
            dat_oe_next = 1'b0;
          end else if (!enb_s_reg[1]) begin
            dat_next    = cell_byte_in;
            take_next   = 1'b1;
            cnt_next    = cnt_reg - CW'(1);
          end
        end
        default: st_next = uxp_pkg::UXP_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg      <= uxp_pkg::UXP_IDLE;
      cnt_reg     <= '0;
      clav_reg    <= 1'b0;
      clav_oe_reg <= 1'b0;
      soc_reg     <= 1'b0;
      dat_reg     <= uxp_pkg::IDLE_BYTE;
      dat_oe_reg  <= 1'b0;
      take_reg    <= 1'b0;
      route_reg   <= 1'b1;
    end else begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      clav_reg    <= clav_next;
      clav_oe_reg <= clav_oe_next;
      soc_reg     <= soc_next;
      dat_reg     <= dat_next;
      dat_oe_reg  <= dat_oe_next;
      take_reg    <= take_next;
      route_reg   <= route_next;
    end
  end

  assign tx_cell_available      = clav_reg;
  assign tx_cell_available_oe   = clav_oe_reg;
  assign tx_start_of_cell       = soc_reg;
  assign tx_start_of_cell_oe    = dat_oe_reg;
  assign tx_cell_byte_bus       = dat_reg;
  assign tx_cell_byte_bus_oe    = dat_oe_reg;
  assign cell_byte_take         = take_reg;
  assign serial_addr_pins_route = route_reg;

  // Bytes handed out since the start flag, for the length check
  logic [CW-1:0] took_reg, took_next;

  always_comb begin
    took_next = took_reg;
    if (take_reg && soc_reg) begin
      took_next = CW'(1);
    end else if (take_reg) begin
      took_next = took_reg + CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      took_reg <= '0;
    end else begin
      took_reg <= took_next;
    end
  end

  // Checks
  strap_tieoff_a: assert property (@(posedge core_clk) disable iff (rst)
    !strap_reg |=> !clav_oe_reg && !dat_oe_reg && !soc_reg)
    else $error("port active while strap low");
  route_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    route_reg == !$past(strap_reg))
    else $error("serial route wrong");
  edge_only_a: assert property (@(posedge core_clk) disable iff (rst)
    strap_reg && !rise |=> $stable(dat_reg) && $stable(soc_reg))
    else $error("output moved off link edge");
  clav_edge_a: assert property (@(posedge core_clk) disable iff (rst)
    strap_reg && !rise |=> $stable(clav_reg) && $stable(clav_oe_reg))
    else $error("cell available moved off link edge");
  soc_start_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(soc_reg) |-> st_reg == uxp_pkg::UXP_SEND && dat_oe_reg)
    else $error("start flag without first byte");
  soc_once_a: assert property (@(posedge core_clk) disable iff (rst)
    soc_reg && rise |=> !soc_reg)
    else $error("start flag past first byte");
  enb_soc_a: assert property (@(posedge core_clk) disable iff (rst)
    strap_reg && rise && sel && !enb_s_reg[1] && cell_ready
    && st_reg == uxp_pkg::UXP_IDLE |=> soc_reg)
    else $error("no start after enable");
  clav_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    strap_reg && rise |=> clav_oe_reg == $past(sel))
    else $error("cell available drive without select");
  clav_val_a: assert property (@(posedge core_clk) disable iff (rst)
    strap_reg && rise && !cell_ready |=> !clav_reg)
    else $error("cell available with no cell");
  byte_take_a: assert property (@(posedge core_clk) disable iff (rst)
    take_reg |-> dat_oe_reg && $changed(cnt_reg))
    else $error("byte taken without drive");
  cell_len_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(dat_oe_reg) && $past(strap_reg) |-> took_reg == CW'(CELL_BYTES))
    else $error("cell length wrong");
  sel_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(clav_oe_reg) |-> $past(adr_s2_reg) == OWN_ADDR)
    else $error("selected on wrong address");
  unsel_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    rise && !sel && st_reg == uxp_pkg::UXP_IDLE |=> !soc_reg && !dat_oe_reg)
    else $error("cell started while not selected");
  cell_sent_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(soc_reg) ##[1:1000] st_reg == uxp_pkg::UXP_IDLE);
  strap_off_c: cover property (@(posedge core_clk) $fell(strap_reg));
  clav_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(clav_reg));
  miss_c: cover property (@(posedge core_clk) disable iff (rst)
    strap_reg && rise && !sel);
  pause_c: cover property (@(posedge core_clk) disable iff (rst)
    dat_oe_reg && rise && enb_s_reg[1]);
endmodule : uxp_tx_port

// *** uxp_pkg.sv ***
package uxp_pkg;
  // Link geometry
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 5;
  localparam int          CELL_BYTES   = 53;
  localparam logic [4:0]  NULL_ADDR    = 5'h1f;
  localparam logic [7:0]  IDLE_BYTE    = 8'h00;
  // Sync stages on pin inputs
  localparam int          SYNC_STAGES  = 2;
  // Transmit state machine
  typedef enum logic [1:0] {
    UXP_IDLE = 2'b00,
    UXP_SEND = 2'b01
  } uxp_state_t;
endpackage : uxp_pkg

// *** uxp_master_model.sv ***
`timescale 1ns/100ps
module uxp_master_model (
  output logic            tx_link_clock,
  output logic            tx_enable_from_master_n,
  output logic [4:0]      tx_slave_select_address,
  input  wire logic       tx_cell_available,
  input  wire logic       tx_cell_available_oe,
  input  wire logic       tx_start_of_cell,
  input  wire logic [7:0] tx_cell_byte_bus,
  input  wire logic       tx_cell_byte_bus_oe
);
  logic [7:0] got_byte [$];
  logic       got_soc  [$];
  logic [1:0] clav_seen;
  // Parked link: clock low, enable and address pulled up
  initial begin
    tx_link_clock           = 1'b0;
    tx_enable_from_master_n = 1'b1;
    tx_slave_select_address = 5'h1f;
  end
  // Frame of n link periods; keeps only bytes it asked for
  task automatic run(input int n, input logic en_n, input logic [4:0] adr);
    got_byte.delete();
    got_soc.delete();
    tx_slave_select_address = adr;
    tx_enable_from_master_n = en_n;
    for (int i = 0; i < n; i++) begin
      #80 tx_link_clock = 1'b1;
      if (i == 1) clav_seen = {tx_cell_available_oe, tx_cell_available};
      if (i > 0 && !en_n && tx_cell_byte_bus_oe === 1'b1) begin
        got_byte.push_back(tx_cell_byte_bus);
        got_soc.push_back(tx_start_of_cell);
      end
      #80 tx_link_clock = 1'b0;
    end
    tx_enable_from_master_n = 1'b1;
    tx_slave_select_address = 5'h1f;
    #160; // Idle link period before the next frame
  endtask : run
endmodule : uxp_master_model

// *** uxp_tx_port_tb.sv ***
`timescale 1ns/100ps
module uxp_tx_port_tb;
  localparam int         NB = 4;
  localparam logic [4:0] ME = 5'h05;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       cell_port_select_strap = 1'b0;
  logic       cell_ready = 1'b0;
  logic [7:0] cell_byte_in = 8'h3c;
  logic       tx_link_clock, tx_enable_from_master_n;
  logic [4:0] adr;
  logic       cell_byte_take, serial_addr_pins_route, tx_cell_available;
  logic       tx_cell_available_oe, tx_start_of_cell, tx_start_of_cell_oe;
  logic [7:0] tx_cell_byte_bus;
  logic       tx_cell_byte_bus_oe;
  int         error_cnt = 0;
  int         total_checks = 0;
  uxp_tx_port #(.CELL_BYTES(NB), .OWN_ADDR(ME)) i_dut (
    .core_clk, .rst, .cell_port_select_strap, .tx_link_clock,
    .tx_enable_from_master_n, .tx_slave_select_address_bit0(adr[0]),
    .serial_addr_pins_in(adr[4:1]), .cell_ready, .cell_byte_in,
    .cell_byte_take, .serial_addr_pins_route, .tx_cell_available,
    .tx_cell_available_oe, .tx_start_of_cell, .tx_start_of_cell_oe,
    .tx_cell_byte_bus, .tx_cell_byte_bus_oe);
  uxp_master_model i_master (
    .tx_link_clock, .tx_enable_from_master_n,
    .tx_slave_select_address(adr), .tx_cell_available,
    .tx_cell_available_oe, .tx_start_of_cell, .tx_cell_byte_bus,
    .tx_cell_byte_bus_oe);
  // Core clock
  always #5 core_clk = ~core_clk;
  // Cell source steps to the next byte after each take
  always @(posedge core_clk)
    if (cell_byte_take === 1'b1) cell_byte_in <= #1 cell_byte_in + 8'h01;
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Strap low: nothing driven, shared pins stay serial
  task automatic t_off;
    cell_ready = 1'b1;
    i_master.run(3, 1'b0, ME);
    check(i_master.clav_seen === 2'b00, "clav driven off");
    check({tx_start_of_cell_oe, tx_cell_byte_bus_oe} === 2'b00, "oe");
    check(serial_addr_pins_route === 1'b1, "pins not serial");
    check(i_master.got_byte.size() == 0, "sent while off");
  endtask : t_off
  // Foreign address, bit 0 then bit 4 wrong: stay silent
  task automatic t_miss;
    cell_port_select_strap = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    for (int k = 0; k < 5; k += 4) begin
      i_master.run(3, 1'b0, ME ^ (5'h01 << k));
      check(i_master.clav_seen[1] === 1'b0, "clav foreign");
      check(i_master.got_byte.size() == 0, "sent to foreign");
    end
    check(serial_addr_pins_route === 1'b0, "pins not address");
  endtask : t_miss
  // Whole cell, start flag with byte 0 only
  task automatic t_cell;
    i_master.run(NB + 1, 1'b0, ME);
    check(i_master.clav_seen === 2'b11, "clav not offered");
    check(i_master.got_byte.size() == NB, "byte count");
    for (int i = 0; i < i_master.got_byte.size(); i++) begin
      check(i_master.got_byte[i] === 8'h3c + i[7:0], "byte value");
      check(i_master.got_soc[i] === (i == 0), "start flag");
    end
  endtask : t_cell
  // No cell ready: clav low, request ignored
  task automatic t_empty;
    cell_ready = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    i_master.run(3, 1'b0, ME);
    check(i_master.clav_seen === 2'b10, "clav not low");
    check(i_master.got_byte.size() == 0, "sent when empty");
  endtask : t_empty
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    t_off;
    t_miss;
    t_cell;
    t_empty;
    wrap_up;
  end
  // Watchdog
  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end
endmodule : uxp_tx_port_tb
